/* smp_pkg.sv */
// Shared constants, state encoding and divider helpers for the serial port.
package smp_pkg;

	localparam int          SMP_WORD_MAX     = 16;
	localparam int          SMP_FIFO_DEPTH   = 16;
	localparam int          SMP_REG_COUNT    = 12;
	localparam logic [15:0] SMP_FRAME_BASE   = 16'h7040; // RULE_19
	localparam logic [6:0]  SMP_BRR_SMALL    = 7'h03;
	localparam logic [7:0]  SMP_DIV_MIN      = 8'h04;
	localparam logic [7:0]  SMP_DIV_MAX      = 8'h80;
	localparam logic [9:0]  SMP_LEAD_SYSTEM_CLOCK  = 10'h003;
	localparam logic [15:0] SMP_WORD_RST     = 16'h0000;
	localparam logic [4:0]  SMP_CNT_RST      = 5'h00;
	localparam logic [7:0]  SMP_HALF_RST     = 8'h01;

	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_LEAD  = 2'b01,
		ST_SHIFT = 2'b11,
		ST_TRAIL = 2'b10
	} smp_state_t;

	// Small settings all give a quarter of the peripheral clock.
	function automatic logic [7:0] smp_div_f(input logic [6:0] brr);
		return (brr < SMP_BRR_SMALL) ? SMP_DIV_MIN : ({1'b0, brr} + 8'h01); // RULE_13
	endfunction

	function automatic logic [15:0] smp_mask_f(input logic [3:0] len_m1);
		return 16'hFFFF >> (4'hF - len_m1);
	endfunction

endpackage

/* smp_sync.sv */
// Two-stage synchroniser for pins arriving from outside the core clock.
`timescale 1ns/1ns
`default_nettype none
module smp_sync
#(
	parameter int W = 4
)
(
	input  wire logic         core_clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	initial
	begin
		if (W < 1)
			$error("smp_sync width must be at least one");
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			meta_r   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // smp_sync
`default_nettype wire

/* smp_fifo.sv */
// Word FIFO whose capacity drops to one entry when bypassed.
`timescale 1ns/1ns
`default_nettype none
module smp_fifo
#(
	parameter int W     = 16,
	parameter int DEPTH = 16
)
(
	input  wire logic         core_clk,
	input  wire logic         reset_n,
	input  wire logic         bypass,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("smp_fifo depth must be a power of two, at least two");
	end

	// Bypassed, the queue behaves as a single holding register.
	assign in_ready  = bypass ? (cnt_r == '0) : (cnt_r != (AW+1)'(DEPTH)); // RULE_11
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem[rd_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge core_clk)
	begin
		if (push)
			mem[wr_r] <= in_data;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wr_r <= wr_r + 1'b1;
			if (pop)
				rd_r <= rd_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end

	a_fifo_no_overfill: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_10
		cnt_r <= (AW+1)'(DEPTH)) else $error("fifo holds more than its depth");
	a_fifo_bypass_one: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_11
		bypass && push |=> !in_ready) else $error("bypassed fifo took a second word");
endmodule // smp_fifo
`default_nettype wire

/* smp_port.sv */
// Master/slave synchronous serial port with queued transmit and receive words.
// What this block does
// RULE_01: Shifts 1-16 bit words in and out together.
// RULE_02: Master drives clock; slave follows external master.
// RULE_03: Shift out on one edge, capture on other.
// RULE_04: Phase bit moves data half cycle earlier.
// RULE_05: Idle high, no delay: drive fall, capture rise.
// RULE_06: Idle high, delay: drive early, capture fall.
// RULE_07: Idle low, no delay: drive rise, capture fall.
// RULE_08: Idle low, delay: drive early, capture rise.
// RULE_09: Transmit can be disabled; reception continues.
// RULE_10: Sixteen-entry transmit and receive queues.
// RULE_11: Enhancement bit cleared bypasses both queues.
// RULE_12: 125 selectable bit rates from rate setting.
// RULE_13: Period four clocks, else setting plus one.
// RULE_14: Divisor 4-128; odd gives unequal halves.
// RULE_15: Enable leads first edge by 1.5t-3, or 2t-3 with phase delay.
// RULE_16: Enable held half period after last edge.
// RULE_17: Software keeps bit clock within speed limits.
// RULE_18: Settings occupy only the low byte.
// RULE_19: Twelve registers framed from base 7040h.
// RULE_20: Polarity bit picks the referenced clock edge.
// RULE_21: Master/slave bit: set master, clear slave.
// RULE_22: Status flags plus interrupt requests for both.
// RULE_23: Slave ignores clock, floats output when deselected.
// RULE_24: Finished word goes to receive queue, flagged.
`timescale 1ns/1ns
`default_nettype none
module smp_port
	import smp_pkg::*;
#(
	parameter int FIFO_DEPTH = smp_pkg::SMP_FIFO_DEPTH
)
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        master_mode,
	input  wire logic        clock_polarity,
	input  wire logic        clock_phase,
	input  wire logic        tx_enable,
	input  wire logic        fifo_enhancement_enable,
	input  wire logic [6:0]  baud_rate,
	input  wire logic [3:0]  word_len_m1,
	input  wire logic [15:0] tx_data,
	input  wire logic        tx_valid,
	output logic             tx_ready,
	output logic      [15:0] rx_data,
	output logic             rx_valid,
	input  wire logic        rx_ready,
	output logic             rx_overrun,
	input  wire logic        rx_overrun_clr,
	input  wire logic        rx_int_en,
	input  wire logic        tx_int_en,
	output logic             rx_irq,
	output logic             tx_irq,
	output logic             busy,
	input  wire logic        serial_bit_clock_i,
	output logic             serial_bit_clock_o,
	output logic             serial_bit_clock_oe_n,
	input  wire logic        slave_in_master_out_i,
	output logic             slave_in_master_out_o,
	output logic             slave_in_master_out_oe_n,
	input  wire logic        slave_out_master_in_i,
	output logic             slave_out_master_in_o,
	output logic             slave_out_master_in_oe_n,
	input  wire logic        slave_transmit_enable_n_i,
	output logic             slave_transmit_enable_n_o,
	output logic             slave_transmit_enable_n_oe_n
);
	import smp_pkg::*;

	smp_state_t  state_r;
	logic [3:0]  pins_s;
	logic        s_sck;
	logic        s_simo;
	logic        s_somi;
	logic        s_ste_n;
	logic        s_sck_d_r;
	logic [7:0]  div_w;
	logic [7:0]  fh_w;
	logic [7:0]  sh_w;
	logic [9:0]  lead_w;
	logic [9:0]  lead_r;
	logic [7:0]  hc_r;
	logic [4:0]  edge_r;
	logic [4:0]  cnt_r;
	logic [15:0] sr_r;
	logic [15:0] shifted_w;
	logic [15:0] load_w;
	logic        out_bit_r;
	logic        sck_r;
	logic        ste_n_r;
	logic        loaded_r;
	logic        rx_push_r;
	logic [15:0] rx_word_r;
	logic        rx_in_ready;
	logic        tx_q_valid;
	logic [15:0] tx_q_data;
	logic        m_tick;
	logic        s_act;
	logic        s_rise;
	logic        s_fall;
	logic        lead_ev;
	logic        trail_ev;
	logic        cap_ev;
	logic        drv_ev;
	logic        in_bit;
	logic        word_done;
	logic        m_start;
	logic        s_fetch;
	logic        do_load;

	smp_sync #(.W(4)) u_sync
	(
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.async_in ({serial_bit_clock_i, slave_in_master_out_i,
		            slave_out_master_in_i, slave_transmit_enable_n_i}),
		.sync_out (pins_s)
	);
	assign {s_sck, s_simo, s_somi, s_ste_n} = pins_s;

	smp_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_tx_fifo // RULE_10
	(
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.bypass    (!fifo_enhancement_enable),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   (tx_data),
		.out_valid (tx_q_valid),
		.out_ready (m_start || s_fetch),
		.out_data  (tx_q_data)
	);

	smp_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_rx_fifo // RULE_10
	(
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.bypass    (!fifo_enhancement_enable),
		.in_valid  (rx_push_r),
		.in_ready  (rx_in_ready),
		.in_data   (rx_word_r),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_data)
	);

	// The first half is the longer one when the divisor is odd.
	assign div_w  = smp_div_f(baud_rate); // RULE_12 RULE_18
	assign sh_w   = div_w >> 1; // RULE_14
	assign fh_w   = div_w - sh_w; // RULE_14
	assign lead_w = (clock_phase ? {1'b0, div_w, 1'b0} : (10'(div_w) + 10'(sh_w)))
	                - SMP_LEAD_SYSTEM_CLOCK - 10'(fh_w); // RULE_15

	assign m_tick  = (state_r == ST_SHIFT) && (hc_r == 8'h01);
	assign s_act   = !master_mode && !s_ste_n; // RULE_23
	assign s_rise  = s_sck && !s_sck_d_r;
	assign s_fall  = !s_sck && s_sck_d_r;
	assign lead_ev = master_mode ? (m_tick && !edge_r[0]) // RULE_02
	                             : (s_act && (clock_polarity ? s_fall : s_rise)); // RULE_20
	assign trail_ev = master_mode ? (m_tick && edge_r[0])
	                              : (s_act && (clock_polarity ? s_rise : s_fall));
	assign cap_ev  = clock_phase ? lead_ev : trail_ev; // RULE_04 RULE_05 RULE_07
	assign drv_ev  = clock_phase ? trail_ev : lead_ev; // RULE_03 RULE_06 RULE_08
	assign in_bit  = master_mode ? s_somi : s_simo;
	assign word_done = cap_ev && (cnt_r == {1'b0, word_len_m1}); // RULE_01

	assign m_start = (state_r == ST_IDLE) && master_mode && tx_q_valid;
	assign s_fetch = !master_mode && tx_q_valid && (s_ste_n ? !loaded_r : word_done);
	assign do_load = m_start || s_fetch || (!master_mode && word_done);
	// With nothing queued a slave answers with zeros.
	assign load_w  = (tx_q_valid ? tx_q_data : SMP_WORD_RST) << (4'hF - word_len_m1);
	assign shifted_w = {sr_r[14:0], in_bit};

	always_ff @(posedge core_clk)
	begin
		s_sck_d_r <= reset_n ? s_sck : 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			state_r <= ST_IDLE;
			lead_r  <= '0;
			hc_r    <= SMP_HALF_RST;
			edge_r  <= SMP_CNT_RST;
			ste_n_r <= 1'b1;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:
				begin
					edge_r <= SMP_CNT_RST;
					if (m_start)
					begin
						state_r <= ST_LEAD;
						lead_r  <= lead_w - 10'h001;
						ste_n_r <= 1'b0; // RULE_15
					end
				end
				ST_LEAD:
				begin
					if (lead_r == '0)
					begin
						state_r <= ST_SHIFT;
						hc_r    <= fh_w;
					end
					else
						lead_r <= lead_r - 10'h001;
				end
				ST_SHIFT:
				begin
					if (m_tick)
					begin
						edge_r <= edge_r + 5'h01;
						hc_r   <= edge_r[0] ? fh_w : sh_w;
						if (edge_r == {word_len_m1, 1'b1})
						begin
							state_r <= ST_TRAIL;
							hc_r    <= sh_w; // RULE_16
						end
					end
					else
						hc_r <= hc_r - 8'h01;
				end
				ST_TRAIL:
				begin
					if (hc_r == 8'h01)
					begin
						state_r <= ST_IDLE;
						ste_n_r <= 1'b1; // RULE_16
					end
					else
						hc_r <= hc_r - 8'h01;
				end
			endcase
		end
	end

	// The clock rests at the polarity level between words.
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			sck_r <= 1'b0;
		else if (state_r == ST_IDLE)
			sck_r <= clock_polarity; // RULE_20
		else if (m_tick)
			sck_r <= !sck_r; // RULE_05 RULE_06 RULE_07 RULE_08
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			sr_r <= SMP_WORD_RST;
		else if (do_load)
			sr_r <= load_w;
		else if (cap_ev)
			sr_r <= shifted_w; // RULE_03
	end

	// With phase delay the first bit must already be on the line before any edge.
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			out_bit_r <= 1'b0;
		else if (do_load && clock_phase && !word_done)
			out_bit_r <= load_w[15]; // RULE_04
		else if (drv_ev)
			out_bit_r <= sr_r[15]; // RULE_03
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			cnt_r <= SMP_CNT_RST;
		else if ((master_mode ? (state_r == ST_IDLE) : s_ste_n) || word_done)
			cnt_r <= SMP_CNT_RST;
		else if (cap_ev)
			cnt_r <= cnt_r + 5'h01;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n || master_mode)
			loaded_r <= 1'b0;
		else if (s_fetch)
			loaded_r <= 1'b1;
		else if (word_done)
			loaded_r <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			rx_push_r <= 1'b0;
			rx_word_r <= SMP_WORD_RST;
		end
		else
		begin
			rx_push_r <= word_done; // RULE_24
			if (word_done)
				rx_word_r <= shifted_w & smp_mask_f(word_len_m1); // RULE_01
		end
	end

	// A new loss in the clearing cycle keeps the flag set.
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			rx_overrun <= 1'b0;
		else if (rx_push_r && !rx_in_ready)
			rx_overrun <= 1'b1; // RULE_22
		else if (rx_overrun_clr)
			rx_overrun <= 1'b0;
	end

	assign rx_irq = rx_int_en && (rx_valid || rx_overrun); // RULE_22
	assign tx_irq = tx_int_en && tx_ready; // RULE_22
	assign busy   = (state_r != ST_IDLE) || s_act;

	assign serial_bit_clock_o           = sck_r;
	assign serial_bit_clock_oe_n        = !master_mode; // RULE_21
	assign slave_transmit_enable_n_o    = ste_n_r;
	assign slave_transmit_enable_n_oe_n = !master_mode;
	assign slave_in_master_out_o        = out_bit_r;
	assign slave_in_master_out_oe_n     = !(master_mode && tx_enable); // RULE_09
	assign slave_out_master_in_o        = out_bit_r;
	assign slave_out_master_in_oe_n     = !(s_act && tx_enable); // RULE_09 RULE_23

	a_lead_enable: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_15
		state_r == ST_LEAD |-> !ste_n_r && sck_r == clock_polarity)
		else $error("clock moved or enable idle during lead");
	a_trail_enable: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_16
		$rose(ste_n_r) |-> $past(state_r) == ST_TRAIL && $stable(sck_r))
		else $error("enable released outside trail");
	a_idle_level: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_20
		state_r == ST_IDLE ##1 state_r == ST_IDLE |-> sck_r == $past(clock_polarity))
		else $error("idle clock not at polarity level");
	a_half_min: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_13
		m_tick |=> !m_tick ##1 $stable(sck_r))
		else $error("clock half period under two cycles");
	a_div_range: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_14
		div_w >= SMP_DIV_MIN && div_w <= SMP_DIV_MAX && fh_w - sh_w == 8'(div_w[0]))
		else $error("divisor out of range or halves wrong");
	a_word_push: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_24
		word_done |=> rx_push_r ##1 !rx_push_r)
		else $error("finished word not pushed exactly once");
	a_slave_float: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_23
		!master_mode && s_ste_n |-> slave_out_master_in_oe_n && !lead_ev && !trail_ev)
		else $error("deselected slave drove or shifted");
	a_tx_off: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_09
		!tx_enable |-> slave_in_master_out_oe_n && slave_out_master_in_oe_n)
		else $error("data line driven with transmit off");
	a_clock_owner: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_02 RULE_21
		serial_bit_clock_oe_n == !master_mode && (master_mode || state_r == ST_IDLE))
		else $error("clock driven by wrong side");
	a_edge_count: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_01
		state_r == ST_SHIFT ##1 state_r == ST_TRAIL |-> edge_r == {word_len_m1, 1'b1} + 5'h01)
		else $error("word ended after wrong edge count");
endmodule // smp_port
`default_nettype wire

/* smp_far_slave.sv */
// Behavioural serial slave that faces the port while it runs as master.
`timescale 1ns/1ns
`default_nettype none
module smp_far_slave
(
	input  wire logic        sck,
	input  wire logic        mosi,
	input  wire logic        ste_n,
	input  wire logic        pol,
	input  wire logic        pha,
	input  wire logic [3:0]  len_m1,
	input  wire logic [15:0] tx_word,
	output logic             miso,
	output logic      [15:0] rx_word
);
	logic [15:0] sh;
	initial miso = 1'b0;
	// With phase delay the first bit must be on the line before any edge.
	always @(negedge ste_n)
	begin
		sh = tx_word;
		rx_word = 16'h0000;
		if (pha)
		begin
			miso = sh[len_m1];
			sh = sh << 1;
		end
	end
	always @(sck)
		if (!ste_n)
		begin
			if ((sck != pol) == pha)
				rx_word = {rx_word[14:0], mosi};
			else
			begin
				miso = sh[len_m1];
				sh = sh << 1;
			end
		end
	// A released line flips so that stale data cannot pass for a good bit.
	always @(posedge ste_n) miso = ~miso;
endmodule // smp_far_slave
`default_nettype wire

/* tb.sv */
// Self-checking bench for the serial port in master and slave roles.
`timescale 1ns/1ns
`default_nettype none
module tb;
	import smp_pkg::*;
	logic        core_clk, reset_n, master_mode, clock_polarity, clock_phase;
	logic        tx_enable, fifo_enhancement_enable, tx_valid, tx_ready;
	logic        rx_valid, rx_ready, rx_overrun, rx_overrun_clr, rx_irq, tx_irq;
	logic        rx_int_en, tx_int_en, busy, tb_sck, tb_mosi, tb_ste, p_miso;
	logic [6:0]  baud_rate;
	logic [3:0]  word_len_m1;
	logic [15:0] tx_data, rx_data, p_tx, p_rx, got;
	logic        serial_bit_clock_o, serial_bit_clock_oe_n;
	logic        slave_in_master_out_o, slave_in_master_out_oe_n;
	logic        slave_out_master_in_o, slave_out_master_in_oe_n;
	logic        slave_transmit_enable_n_o, slave_transmit_enable_n_oe_n;
	logic        sck_q, ste_q;
	int          fail_count, cmp_count, seed, cyc, t_ste, t1, t3, tl, t_end, ntog;
	int          md, k, i, e;
	logic [15:0] exp_q[$];
	wire serial_bit_clock_i = serial_bit_clock_oe_n ? tb_sck : serial_bit_clock_o;
	wire slave_in_master_out_i = slave_in_master_out_oe_n ? tb_mosi : slave_in_master_out_o;
	wire slave_out_master_in_i = slave_out_master_in_oe_n ? p_miso : slave_out_master_in_o;
	wire slave_transmit_enable_n_i =
		slave_transmit_enable_n_oe_n ? tb_ste : slave_transmit_enable_n_o;

	smp_port smp_port_inst (.core_clk, .reset_n, .master_mode, .clock_polarity,
		.clock_phase, .tx_enable, .fifo_enhancement_enable, .baud_rate, .word_len_m1,
		.tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .rx_overrun,
		.rx_overrun_clr, .rx_int_en, .tx_int_en, .rx_irq, .tx_irq, .busy,
		.serial_bit_clock_i, .serial_bit_clock_o, .serial_bit_clock_oe_n,
		.slave_in_master_out_i, .slave_in_master_out_o, .slave_in_master_out_oe_n,
		.slave_out_master_in_i, .slave_out_master_in_o, .slave_out_master_in_oe_n,
		.slave_transmit_enable_n_i, .slave_transmit_enable_n_o,
		.slave_transmit_enable_n_oe_n);
	smp_far_slave smp_far_slave_inst (.sck(serial_bit_clock_i),
		.mosi(slave_in_master_out_i), .ste_n(slave_transmit_enable_n_i),
		.pol(clock_polarity), .pha(clock_phase), .len_m1(word_len_m1), .tx_word(p_tx),
		.miso(p_miso), .rx_word(p_rx));

	always #5 core_clk = ~core_clk;
	// An undriven data line toggles so that it never looks like held data.
	always @(negedge core_clk)
		if (master_mode)
			tb_mosi <= ~tb_mosi;
	// Edge timing of the master frame, sampled where the outputs have settled.
	always @(negedge core_clk)
	begin
		cyc++;
		if (ste_q === 1'b1 && slave_transmit_enable_n_o === 1'b0)
		begin
			t_ste = cyc;
			ntog = 0;
		end
		if (!slave_transmit_enable_n_o && serial_bit_clock_o !== sck_q)
		begin
			ntog++;
			tl = cyc;
			if (ntog == 1)
				t1 = cyc;
			if (ntog == 3)
				t3 = cyc;
		end
		if (ste_q === 1'b0 && slave_transmit_enable_n_o === 1'b1)
			t_end = cyc;
		sck_q = serial_bit_clock_o;
		ste_q = slave_transmit_enable_n_o;
	end

	task automatic give_verdict;
		$display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
		cmp_count++;
		if (g !== ex)
		begin
			$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, g);
			fail_count++;
		end
	endtask

	task automatic waitv(input int w, input logic v);
		int n;
		n = 0;
		while ((w == 0 ? busy : (w == 1 ? rx_valid : tx_ready)) !== v)
		begin
			@(negedge core_clk);
			n++;
			if (n > 20000)
			begin
				chk("wait bound", 0, w + 1);
				give_verdict;
			end
		end
	endtask

	task automatic push(input logic [15:0] w);
		tx_data = w;
		tx_valid = 1;
		waitv(2, 1);
		chk("tx irq", 1, tx_irq);
		@(negedge core_clk);
		tx_valid = 0;
	endtask

	task automatic pop;
		waitv(1, 1);
		chk("rx word", exp_q.pop_front(), rx_data);
		chk("rx irq", 1, rx_irq);
		rx_ready = 1;
		@(negedge core_clk);
		rx_ready = 0;
	endtask

	task automatic xfer(input logic [15:0] w, input logic [15:0] pw);
		int d;
		logic [15:0] m;
		d = (baud_rate < 3) ? 4 : baud_rate + 1;
		m = 16'hFFFF >> (15 - word_len_m1);
		p_tx = pw;
		exp_q.push_back(pw & m);
		push(w);
		waitv(0, 1);
		waitv(0, 0);
		// One more edge so the timing monitor has logged the release.
		@(negedge core_clk);
		chk("toggles", 2 * (word_len_m1 + 1), ntog);
		chk("lead", clock_phase ? 2 * d - 3 : d + d / 2 - 3, t1 - t_ste);
		if (ntog > 2)
			chk("period", d, t3 - t1);
		chk("trail", d / 2, t_end - tl);
		chk("idle level", clock_polarity, serial_bit_clock_o);
		pop();
		if (tx_enable)
			chk("far rx", w & m, p_rx);
	endtask

	initial
	begin
		seed = 76241;
		{core_clk, reset_n, clock_polarity, clock_phase, tx_valid, rx_ready} = '0;
		{rx_overrun_clr, tb_sck, tb_mosi, p_tx, tx_data} = '0;
		{master_mode, tx_enable, fifo_enhancement_enable, rx_int_en, tx_int_en} = '1;
		tb_ste = 1;
		baud_rate = 7'h07;
		word_len_m1 = 4'h0;
		repeat (16) @(negedge core_clk);
		reset_n = 1;
		for (md = 0; md < 4; md++)
		begin
			clock_polarity = md[1];
			clock_phase = md[0];
			for (k = 0; k < 3; k++)
			begin
				tx_enable = (k != 1);
				baud_rate = (md == 0 && k == 0) ? 7'h7F : 7'h07 + 7'({$random(seed)} % 10);
				word_len_m1 = 4'($random(seed));
				@(negedge core_clk);
				chk("mosi oe", !tx_enable, slave_in_master_out_oe_n);
				xfer(16'($random(seed)), 16'($random(seed)));
			end
		end
		$display("test modes done");
		word_len_m1 = 4'h0;
		p_tx = 16'h0001;
		for (e = 0; e < 2; e++)
		begin
			fifo_enhancement_enable = e[0];
			for (i = 0; i <= (e ? 16 : 1); i++)
			begin
				if (i < (e ? 16 : 1))
					exp_q.push_back(16'h0001);
				push(16'(i));
				waitv(0, 1);
				waitv(0, 0);
				chk("overrun", i == (e ? 16 : 1), rx_overrun);
			end
			for (i = 0; i < (e ? 16 : 1); i++)
				pop();
			chk("drained", 0, rx_valid);
			rx_overrun_clr = 1;
			@(negedge core_clk);
			rx_overrun_clr = 0;
			@(negedge core_clk);
			chk("overrun clr", 0, rx_overrun);
		end
		$display("test overrun done");
		{master_mode, clock_polarity, clock_phase} = '0;
		word_len_m1 = 4'h7;
		for (i = 0; i < 8; i++)
		begin
			#62 tb_sck = 1;
			#63 tb_sck = 0;
		end
		@(negedge core_clk);
		chk("ignored clock", 0, rx_valid);
		chk("somi float", 1, slave_out_master_in_oe_n);
		push(16'h00A5);
		exp_q.push_back(16'h003C);
		got = 16'h0000;
		tb_ste = 0;
		#250;
		// The bench master drives on the rising edge and samples on the falling one.
		for (i = 7; i >= 0; i--)
		begin
			#62 tb_sck = 1;
			tb_mosi = 1'(8'h3C >> i);
			#63 got = {got[14:0], slave_out_master_in_i};
			tb_sck = 0;
		end
		#125 tb_ste = 1;
		@(negedge core_clk);
		chk("slave out", 16'h00A5, got);
		pop();
		{rx_int_en, tx_int_en} = '0;
		@(negedge core_clk);
		chk("irq masked", 0, {rx_irq, tx_irq});
		$display("test slave done");
		give_verdict;
	end
endmodule // tb
`default_nettype wire
